/* sorc_host_model.sv */
/*
 * Host controller model for the servo offset register bank: issues
 * whole control words and reads on the plain register port.
 * Assumes a slave that never stalls and read data one cycle late.
 */
`timescale 1ns/100ps
`default_nettype none
module sorc_host_model (
	// Clock
	input  wire logic        sys_clk,
	// Register port
	output logic      [3:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_write,
	output logic             reg_read,
	input  wire logic [15:0] reg_rdata
);
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task automatic write_word(input logic [3:0] sel, input logic [11:0] fields);
		@(posedge sys_clk);
		reg_wdata <= {sel, fields};
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		// Stale data would hide a write taken late, so show its inverse
		reg_wdata <= ~{sel, fields};
		#1;
	endtask : write_word
	task automatic read_word(input logic [3:0] addr, output logic [15:0] data,
		output logic [15:0] after);
		@(posedge sys_clk);
		reg_addr <= addr;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		reg_addr <= ~addr;
		#1 data = reg_rdata;
		@(posedge sys_clk);
		#1 after = reg_rdata;
	endtask : read_word
endmodule : sorc_host_model
`default_nettype wire

/* sorc_pkg.sv */
/*
 * Package for the servo offset control register bank: word layout,
 * register select codes, field positions, reset values and decode codes.
 * Assumes a host delivers whole 16-bit control words, one per strobe.
 */
// Behaviour
// R1: Upper nibble selects register 1011, 1100, 1101.
// R2: Bits 11:10 radial: shared low-frequency offset.
// R3: Bit 9 radial: normal or triple range.
// R4: Bit 8 radial: track-count bandwidth select.
// R5: Bits 7:4 radial: E input trim.
// R6: Bits 3:0 radial: F input trim.
// R7: Bit 11 central A/B: phase RF test route.
// R8: Bits 10:8 central A/B: central test select.
// R9: Bits 7:4 central A/B: A input trim.
// R10: Bits 3:0 central A/B: B input trim.
// R11: Bit 11 central C/D: float servo outputs.
// R12: Bits 7:4 central C/D: C input trim.
// R13: Bits 3:0 central C/D: D trim; 10:8 unused.
// R14: Channel switch bit 1: mute channel A.
// R15: Channel switch bit 0: invert channel A.
// R16: Channel switch bit 2: invert channel B.
// R17: Code 1000 selects channel switch; 7:3 others.
// R18: Only matching register updates; others hold.
package sorc_pkg;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned SEL_LSB = 12;
	localparam logic [3:0] SEL_CHAN_SWITCH = 4'h8;
	localparam logic [3:0] SEL_RADIAL = 4'hb;
	localparam logic [3:0] SEL_CENTRAL_AB = 4'hc;
	localparam logic [3:0] SEL_CENTRAL_CD = 4'hd;
	localparam int unsigned BIT_LF_OFFS_LSB = 10;
	localparam int unsigned BIT_RANGE = 9;
	localparam int unsigned BIT_BANDWIDTH = 8;
	localparam int unsigned BIT_HI_TRIM_LSB = 4;
	localparam int unsigned BIT_LO_TRIM_LSB = 0;
	localparam int unsigned BIT_PHASE_RF = 11;
	localparam int unsigned BIT_TEST_SEL_LSB = 8;
	localparam int unsigned BIT_FLOAT = 11;
	localparam int unsigned BIT_A_INV = 0;
	localparam int unsigned BIT_A_MUTE = 1;
	localparam int unsigned BIT_B_INV = 2;
	localparam int unsigned BIT_B_MUTE = 3;
	localparam int unsigned BIT_C_INV = 4;
	localparam int unsigned BIT_C_MUTE = 5;
	localparam int unsigned BIT_D_INV = 6;
	localparam int unsigned BIT_D_MUTE = 7;
	localparam logic [11:0] RESET_FIELDS = 12'h000;
	// Central test output selections
	localparam logic [2:0] TEST_NORMAL = 3'h0;
	localparam logic [2:0] TEST_FILTER_CURRENT = 3'h1;
	localparam logic [2:0] TEST_SUM = 3'h3;
	localparam logic [2:0] TEST_CHAN_A = 3'h4;
	// Low-frequency offset steps in mV, normal and triple range
	localparam int unsigned LF_STEP_MV = 5;
	localparam int unsigned RANGE_TRIPLE = 3;
endpackage : sorc_pkg

/* sorc_regs.sv */
/*
 * Servo offset control register bank. Takes 16-bit control words on a
 * plain write port, stores the fields of four write-only registers and
 * drives every setting as a registered output, plus decoded helpers.
 * Assumes one clock (sys_clk, 125 MHz) and a synchronous active-high reset.
 * Reads return a status word: last select code accepted, settings echo.
 */
`timescale 1ns/100ps
`default_nettype none
module sorc_regs (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [15:0] reg_rdata,
	// Radial register settings
	output logic      [1:0]  low_freq_offset,
	output logic             offset_range_scale,
	output logic             track_count_bandwidth,
	output logic      [3:0]  radial_e_trim,
	output logic      [3:0]  radial_f_trim,
	// Central A/B register settings
	output logic             phase_rf_test_route,
	output logic      [2:0]  central_test_select,
	output logic      [3:0]  central_a_trim,
	output logic      [3:0]  central_b_trim,
	// Central C/D register settings
	output logic             servo_outputs_float,
	output logic      [3:0]  central_c_trim,
	output logic      [3:0]  central_d_trim,
	// Channel switch settings
	output logic             chan_a_silence,
	output logic             chan_a_invert,
	output logic             chan_b_invert,
	output logic      [4:0]  chan_switch_upper,
	// Decoded helpers
	output logic      [5:0]  low_freq_offset_mv,
	output logic             servo_out_enable
);
	typedef struct packed {
		logic [11:0] radial;
		logic [11:0] central_ab;
		logic [11:0] central_cd;
		logic [7:0]  chan_switch;
		logic [15:0] rdata;
		logic [3:0]  last_sel;
		logic [5:0]  lf_mv;
		logic        out_en;
	} sorc_state_s;

	sorc_state_s state;
	sorc_state_s next_state;

	logic [11:0] fields;
	logic        hit_radial;
	logic        hit_central_ab;
	logic        hit_central_cd;
	logic        hit_chan_switch;

	// Word arrives on write data; reg_addr is ignored for writes because
	// the select code travels inside the word itself.
	sorc_word_decode u_decode (
		.word            (reg_wdata),
		.fields          (fields),
		.hit_radial      (hit_radial),
		.hit_central_ab  (hit_central_ab),
		.hit_central_cd  (hit_central_cd),
		.hit_chan_switch (hit_chan_switch)
	);

	// Offset in mV for the shared low-frequency DAC
	function automatic logic [5:0] lf_mv(input logic [1:0] code, input logic triple);
		logic [5:0] base;
		base = 6'(code) * 6'(sorc_pkg::LF_STEP_MV);
		lf_mv = triple ? 6'(base * 6'(sorc_pkg::RANGE_TRIPLE)) : base;
	endfunction : lf_mv

	always_comb begin
		next_state = state;
		// R18: only the matching register updates
		if (reg_write) begin
			// R1: radial select
			if (hit_radial) begin
				next_state.radial = fields;
			end
			if (hit_central_ab) begin
				next_state.central_ab = fields;
			end
			if (hit_central_cd) begin
				next_state.central_cd = fields;
			end
			// R17: channel switch low byte
			if (hit_chan_switch) begin
				next_state.chan_switch = fields[7:0];
			end
			if (hit_radial || hit_central_ab || hit_central_cd || hit_chan_switch) begin
				next_state.last_sel = reg_wdata[15:sorc_pkg::SEL_LSB];
			end
		end
		// R2: low-frequency offset scaled by range
		next_state.lf_mv = lf_mv(next_state.radial[sorc_pkg::BIT_LF_OFFS_LSB +: 2],
			next_state.radial[sorc_pkg::BIT_RANGE]);
		// R11: float servo outputs
		next_state.out_en = ~next_state.central_cd[sorc_pkg::BIT_FLOAT];
		// Read port: registers are write-only, so status is read back
		next_state.rdata = 16'h0000;
		if (reg_read) begin
			unique case (reg_addr)
				sorc_pkg::SEL_RADIAL: next_state.rdata = {sorc_pkg::SEL_RADIAL, state.radial};
				sorc_pkg::SEL_CENTRAL_AB: next_state.rdata = {sorc_pkg::SEL_CENTRAL_AB, state.central_ab};
				sorc_pkg::SEL_CENTRAL_CD: next_state.rdata = {sorc_pkg::SEL_CENTRAL_CD,
					state.central_cd[11], 3'h0, state.central_cd[7:0]};
				sorc_pkg::SEL_CHAN_SWITCH: next_state.rdata = {sorc_pkg::SEL_CHAN_SWITCH, 4'h0,
					state.chan_switch};
				4'h0: next_state.rdata = {12'h000, state.last_sel};
				default: next_state.rdata = 16'h0000;
			endcase
		end
		if (reset) begin
			next_state.radial = sorc_pkg::RESET_FIELDS;
			next_state.central_ab = sorc_pkg::RESET_FIELDS;
			next_state.central_cd = sorc_pkg::RESET_FIELDS;
			next_state.chan_switch = sorc_pkg::RESET_FIELDS[7:0];
			next_state.rdata = 16'h0000;
			next_state.last_sel = 4'h0;
			next_state.lf_mv = 6'h00;
			next_state.out_en = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		state <= next_state;
	end

	always_comb begin
		reg_rdata = state.rdata;
		// R2: shared offset code
		low_freq_offset = state.radial[sorc_pkg::BIT_LF_OFFS_LSB +: 2];
		// R3: range scale
		offset_range_scale = state.radial[sorc_pkg::BIT_RANGE];
		// R4: bandwidth select
		track_count_bandwidth = state.radial[sorc_pkg::BIT_BANDWIDTH];
		// R5: E trim
		radial_e_trim = state.radial[sorc_pkg::BIT_HI_TRIM_LSB +: 4];
		// R6: F trim
		radial_f_trim = state.radial[sorc_pkg::BIT_LO_TRIM_LSB +: 4];
		// R7: phase RF route
		phase_rf_test_route = state.central_ab[sorc_pkg::BIT_PHASE_RF];
		// R8: central test select
		central_test_select = state.central_ab[sorc_pkg::BIT_TEST_SEL_LSB +: 3];
		// R9: A trim
		central_a_trim = state.central_ab[sorc_pkg::BIT_HI_TRIM_LSB +: 4];
		// R10: B trim
		central_b_trim = state.central_ab[sorc_pkg::BIT_LO_TRIM_LSB +: 4];
		// R11: float flag
		servo_outputs_float = state.central_cd[sorc_pkg::BIT_FLOAT];
		// R12: C trim
		central_c_trim = state.central_cd[sorc_pkg::BIT_HI_TRIM_LSB +: 4];
		// R13: D trim
		central_d_trim = state.central_cd[sorc_pkg::BIT_LO_TRIM_LSB +: 4];
		// R14: mute A
		chan_a_silence = state.chan_switch[sorc_pkg::BIT_A_MUTE];
		// R15: invert A
		chan_a_invert = state.chan_switch[sorc_pkg::BIT_A_INV];
		// R16: invert B
		chan_b_invert = state.chan_switch[sorc_pkg::BIT_B_INV];
		chan_switch_upper = state.chan_switch[sorc_pkg::BIT_B_MUTE +: 5];
		low_freq_offset_mv = state.lf_mv;
		servo_out_enable = state.out_en;
	end

	// Assertions
	property p_radial_write;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hb |=> radial_e_trim == $past(reg_wdata[7:4])
			&& radial_f_trim == $past(reg_wdata[3:0]) && low_freq_offset == $past(reg_wdata[11:10]);
	endproperty
	a_radial_write: assert property (p_radial_write) else $error("radial write lost"); // R1
	property p_range;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hb |=> offset_range_scale == $past(reg_wdata[9])
			&& track_count_bandwidth == $past(reg_wdata[8]);
	endproperty
	a_range: assert property (p_range) else $error("range or bandwidth wrong"); // R3
	property p_lf_mv;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hb && reg_wdata[11:9] == 3'h7 |=> low_freq_offset_mv == 6'h2d;
	endproperty
	a_lf_mv: assert property (p_lf_mv) else $error("triple range offset not 45 mV"); // R2
	property p_ab_write;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hc |=> central_test_select == $past(reg_wdata[10:8])
			&& phase_rf_test_route == $past(reg_wdata[11]) && central_a_trim == $past(reg_wdata[7:4])
			&& central_b_trim == $past(reg_wdata[3:0]);
	endproperty
	a_ab_write: assert property (p_ab_write) else $error("central A/B write lost"); // R8
	property p_float;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hd |=> servo_outputs_float == $past(reg_wdata[11])
			&& servo_out_enable == !$past(reg_wdata[11]) && central_d_trim == $past(reg_wdata[3:0]);
	endproperty
	a_float: assert property (p_float) else $error("float mode mismatch"); // R11
	property p_switch;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'h8 |=> chan_a_silence == $past(reg_wdata[1])
			&& chan_a_invert == $past(reg_wdata[0]) && chan_b_invert == $past(reg_wdata[2]);
	endproperty
	a_switch: assert property (p_switch) else $error("channel switch write lost"); // R14
	property p_hold;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] != 4'hb |=> $stable(radial_e_trim) && $stable(low_freq_offset);
	endproperty
	a_hold: assert property (p_hold) else $error("radial changed on other select"); // R18
	property p_hold_cd;
		@(posedge sys_clk) disable iff (reset)
		!(reg_write && reg_wdata[15:12] == 4'hd) |=> $stable(central_c_trim) && $stable(servo_outputs_float);
	endproperty
	a_hold_cd: assert property (p_hold_cd) else $error("C/D changed without write"); // R18
	property p_cd_write;
		@(posedge sys_clk) disable iff (reset)
		reg_write && reg_wdata[15:12] == 4'hd |=> central_c_trim == $past(reg_wdata[7:4]);
	endproperty
	a_cd_write: assert property (p_cd_write) else $error("C trim write lost"); // R12
	property p_hold_ab;
		@(posedge sys_clk) disable iff (reset)
		!(reg_write && reg_wdata[15:12] == 4'hc) |=> $stable(central_a_trim)
			&& $stable(central_test_select) && $stable(phase_rf_test_route);
	endproperty
	a_hold_ab: assert property (p_hold_ab) else $error("A/B changed without write"); // R18
	property p_hold_switch;
		@(posedge sys_clk) disable iff (reset)
		!(reg_write && reg_wdata[15:12] == 4'h8) |=> $stable(chan_a_silence)
			&& $stable(chan_b_invert) && $stable(chan_switch_upper);
	endproperty
	a_hold_switch: assert property (p_hold_switch) else $error("switch changed without write"); // R18
endmodule : sorc_regs
`default_nettype wire

/* sorc_word_decode.sv */
/*
 * Decoder for one incoming control word: splits select and field bits
 * and flags which bank register it addresses. Pure combinational logic.
 * Assumes the caller qualifies the result with its own write strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module sorc_word_decode (
	// Control word
	input  wire logic [15:0] word,
	// Decoded
	output logic      [11:0] fields,
	output logic             hit_radial,
	output logic             hit_central_ab,
	output logic             hit_central_cd,
	output logic             hit_chan_switch
);
	logic [3:0] sel;

	always_comb begin
		sel = word[15:sorc_pkg::SEL_LSB];
		fields = word[sorc_pkg::SEL_LSB-1:0];
		// R1: select code match
		hit_radial = (sel == sorc_pkg::SEL_RADIAL);
		hit_central_ab = (sel == sorc_pkg::SEL_CENTRAL_AB);
		hit_central_cd = (sel == sorc_pkg::SEL_CENTRAL_CD);
		// R17: channel switch code
		hit_chan_switch = (sel == sorc_pkg::SEL_CHAN_SWITCH);
	end
endmodule : sorc_word_decode
`default_nettype wire

/* tb.sv */
/*
 * Self-checking bench for the servo offset register bank.
 * Assumes the host model drives every register port input.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic sys_clk, reset, reg_write, reg_read;
	logic [3:0] reg_addr, e_t, f_t, a_t, b_t, c_t, d_t;
	logic [15:0] reg_wdata, reg_rdata, rd, rd2;
	logic [1:0] lfo;
	logic rng, bw, ph, flt, asl, ainv, binv, oen;
	logic [2:0] tsel;
	logic [4:0] swu;
	logic [5:0] mv;
	int fail_count = 0;
	int comparisons = 0;
	wire logic [11:0] rad = {lfo, rng, bw, e_t, f_t};
	wire logic [11:0] ab = {ph, tsel, a_t, b_t};
	wire logic [8:0] cd = {flt, c_t, d_t};
	wire logic [7:0] sw = {swu, binv, asl, ainv};
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	sorc_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	sorc_regs u_dut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .low_freq_offset(lfo), .offset_range_scale(rng),
		.track_count_bandwidth(bw), .radial_e_trim(e_t), .radial_f_trim(f_t),
		.phase_rf_test_route(ph), .central_test_select(tsel), .central_a_trim(a_t),
		.central_b_trim(b_t), .servo_outputs_float(flt), .central_c_trim(c_t),
		.central_d_trim(d_t), .chan_a_silence(asl), .chan_a_invert(ainv),
		.chan_b_invert(binv), .chan_switch_upper(swu), .low_freq_offset_mv(mv),
		.servo_out_enable(oen));
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask : chk
	task automatic t_reset();
		chk("radial", 16'h0000, {4'h0, rad});
		chk("central_ab", 16'h0000, {4'h0, ab});
		chk("central_cd", 16'h0000, {7'h00, cd});
		chk("switch", 16'h0000, {8'h00, sw});
		chk("servo_out_enable", 16'h0001, {15'h0000, oen});
		chk("rdata", 16'h0000, reg_rdata);
		$display("test reset done");
	endtask : t_reset
	task automatic t_radial();
		u_host.write_word(4'hb, 12'h5a3);
		chk("radial", 16'h05a3, {4'h0, rad});
		chk("lf_mv", 16'h0005, {10'h000, mv});
		chk("central_ab", 16'h0000, {4'h0, ab});
		u_host.read_word(4'hb, rd, rd2);
		chk("read radial", 16'hb5a3, rd);
		chk("read after", 16'h0000, rd2);
		$display("test radial done");
	endtask : t_radial
	task automatic t_lf_table();
		logic [11:0] f;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 2; r++) begin
				f = {c[1:0], r[0], 1'b1, 8'h96};
				u_host.write_word(4'hb, f);
				chk("radial", {4'h0, f}, {4'h0, rad});
				chk("lf_mv", 16'(c * 5 * (r ? 3 : 1)), {10'h000, mv});
			end
		end
		$display("test low frequency table done");
	endtask : t_lf_table
	task automatic t_central_ab();
		logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
		logic [11:0] f;
		for (int i = 0; i < 7; i++) begin
			f = {i[0], codes[i], 4'(i + 8), 4'(7 - i)};
			u_host.write_word(4'hc, f);
			chk("central_ab", {4'h0, f}, {4'h0, ab});
			chk("radial", 16'h0f96, {4'h0, rad});
		end
		u_host.read_word(4'hc, rd, rd2);
		chk("read central_ab", {4'hc, f}, rd);
		$display("test central ab done");
	endtask : t_central_ab
	task automatic t_central_cd();
		u_host.write_word(4'hd, 12'hfc5);
		chk("central_cd", 16'h01c5, {7'h00, cd});
		chk("servo_out_enable", 16'h0000, {15'h0000, oen});
		u_host.read_word(4'hd, rd, rd2);
		chk("read central_cd", 16'hd8c5, rd);
		u_host.write_word(4'hd, 12'h03a);
		chk("central_cd", 16'h003a, {7'h00, cd});
		chk("servo_out_enable", 16'h0001, {15'h0000, oen});
		$display("test central cd done");
	endtask : t_central_cd
	task automatic t_switch();
		u_host.write_word(4'h8, 12'hf07);
		chk("switch", 16'h0007, {8'h00, sw});
		u_host.read_word(4'h8, rd, rd2);
		chk("read switch", 16'h8007, rd);
		u_host.write_word(4'h8, 12'h0f8);
		chk("switch", 16'h00f8, {8'h00, sw});
		chk("central_cd", 16'h003a, {7'h00, cd});
		$display("test switch done");
	endtask : t_switch
	task automatic t_refuse();
		logic [3:0] bad [7] = '{4'h0, 4'h1, 4'h7, 4'h9, 4'ha, 4'he, 4'hf};
		logic [11:0] r0, a0;
		r0 = rad;
		a0 = ab;
		foreach (bad[i]) begin
			u_host.write_word(bad[i], 12'hfff);
			chk("radial", {4'h0, r0}, {4'h0, rad});
			chk("central_ab", {4'h0, a0}, {4'h0, ab});
			chk("central_cd", 16'h003a, {7'h00, cd});
			chk("switch", 16'h00f8, {8'h00, sw});
		end
		u_host.read_word(4'h5, rd, rd2);
		chk("read unmapped", 16'h0000, rd);
		u_host.read_word(4'h0, rd, rd2);
		chk("read last select", 16'h0008, rd);
		$display("test refused selects done");
	endtask : t_refuse
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		reset = 1'b1;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_radial();
		t_lf_table();
		t_central_ab();
		t_central_cd();
		t_switch();
		t_refuse();
		finish_test();
	end
endmodule : tb
`default_nettype wire
